// file: design/ddr_ctrl.sv
// dram controller: register port, fabric port and memory pin logic
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl (
  input wire logic clock,
  input wire logic nrst,
  input wire logic second_pll,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fab_valid,
  input wire ddr_ctrl_pkg::fab_req_t fab_req,
  output logic fab_ready,
  output logic fab_rvalid,
  output logic [31:0] fab_rdata,
  output logic mem_clk_p,
  output logic mem_clk_n,
  output logic mem_cke,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [2:0] mem_ba,
  output logic [13:0] mem_a,
  output logic [3:0] mem_dqm_n,
  input wire logic [31:0] mem_dq_i,
  output logic [31:0] mem_dq_o,
  output logic [3:0] mem_dq_oe_n,
  input wire logic [3:0] mem_dqs_i,
  output logic [3:0] mem_dqs_o,
  output logic [3:0] mem_dqs_n_o,
  output logic [3:0] mem_dqs_oe_n,
  output logic [1:0] strobe_gate_loop_o,
  input wire logic [1:0] strobe_gate_loop_i,
  output logic [1:0] termination_ctrl
);
  typedef enum {
    S_INIT_WAIT, S_INIT_PRE, S_INIT_EMR, S_INIT_MR, S_INIT_REF, S_IDLE,
    S_ACT, S_CMD, S_DATA, S_PRE, S_REF, S_SR, S_SR_EXIT
  } link_state_t;

  // ---------------- bus domain ----------------
  ddr_ctrl_pkg::mem_cfg_t cfg_reg;
  logic [15:0] refi_reg;
  logic cfg_tgl_reg, req_tgl_reg, pending_reg;
  ddr_ctrl_pkg::fab_req_t req_reg;
  logic ack_prev_reg;
  logic ack_s, sr_s, init_s;
  logic ack_tgl_reg;
  logic [31:0] rdata_link_reg;
  logic self_ref_reg, init_done_reg;

  wire wr_cfg = reg_wr && (reg_addr == ddr_ctrl_pkg::REG_CFG);
  wire wr_refi = reg_wr && (reg_addr == ddr_ctrl_pkg::REG_REFRESH);
  wire [31:0] status_word = {29'h0, init_s, sr_s, pending_reg};
  wire [31:0] read_mux = (reg_addr == ddr_ctrl_pkg::REG_CFG) ? {23'h0, cfg_reg} :
                         (reg_addr == ddr_ctrl_pkg::REG_REFRESH) ? {16'h0, refi_reg} :
                         (reg_addr == ddr_ctrl_pkg::REG_STATUS) ? status_word : 32'h0;
  wire ack_edge = ack_s != ack_prev_reg;
  // R16 accesses enter only through the fabric port
  wire take_req = fab_valid && fab_ready;

  sync2 #(.W(3)) u_to_bus (
    .clock(clock),
    .d({ack_tgl_reg, self_ref_reg, init_done_reg}),
    .q({ack_s, sr_s, init_s})
  );

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg_reg <= ddr_ctrl_pkg::CFG_RESET;
      refi_reg <= ddr_ctrl_pkg::REFRESH_RESET;
      cfg_tgl_reg <= 1'b0;
      reg_rdata <= 32'h0;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= reg_wdata[8:0];
      end
      if (wr_refi) begin
        refi_reg <= reg_wdata[15:0];
      end
      cfg_tgl_reg <= cfg_tgl_reg ^ (wr_cfg || wr_refi);
      reg_rdata <= reg_rd ? read_mux : 32'h0;
    end
  end

  // request handshake: fields stay frozen while pending
  always_ff @(posedge clock) begin
    if (!nrst) begin
      req_reg <= '0;
      req_tgl_reg <= 1'b0;
      pending_reg <= 1'b0;
      ack_prev_reg <= 1'b0;
      fab_ready <= 1'b0;
      fab_rvalid <= 1'b0;
      fab_rdata <= 32'h0;
    end else begin
      ack_prev_reg <= ack_s;
      fab_ready <= !pending_reg && !take_req && !ack_edge;
      fab_rvalid <= ack_edge && !req_reg.write;
      if (ack_edge) begin
        pending_reg <= 1'b0;
        fab_rdata <= rdata_link_reg;
      end else if (take_req) begin
        req_reg <= fab_req;
        req_tgl_reg <= !req_tgl_reg;
        pending_reg <= 1'b1;
      end
    end
  end

  // ---------------- link domain ----------------
  logic lrst_n, req_s, cfg_s, req_prev_reg, cfg_prev_reg, req_open_reg;
  ddr_ctrl_pkg::mem_cfg_t lcfg_reg;
  logic [15:0] lrefi_reg, wait_reg;
  link_state_t state_reg;
  logic ph_reg;
  logic [1:0] mr_cl_reg;
  logic [4:0] dcnt_reg;
  logic [2:0] beat_reg, cap_reg;
  logic [1:0] gate_s;
  logic [31:0] dq_s;
  logic dqs_s, dqs_prev_reg;
  logic ref_need, ref_urgent, ref_served;
  ddr_ctrl_pkg::mem_cmd_t cmd_next;

  sync2 #(.W(1)) u_rst (.clock(second_pll), .d(nrst), .q(lrst_n));
  sync2 #(.W(2)) u_to_link (
    .clock(second_pll),
    .d({req_tgl_reg, cfg_tgl_reg}),
    .q({req_s, cfg_s})
  );
  sync2 #(.W(35)) u_pins (
    .clock(second_pll),
    .d({strobe_gate_loop_i, mem_dqs_i[0], mem_dq_i}),
    .q({gate_s, dqs_s, dq_s})
  );

  function automatic logic [26:0] word_addr(input logic [27:0] a, input logic narrow);
    word_addr = narrow ? a[27:1] : {1'b0, a[27:2]};
  endfunction : word_addr

  // R9 column width 8 to 11 bits
  function automatic logic [10:0] col_of(input logic [26:0] wa, input logic [1:0] pg);
    col_of = wa[10:0] & 11'((12'h100 << pg) - 12'h001);
  endfunction : col_of

  // R8 bank field 0 to 3 bits above the column
  function automatic logic [2:0] bank_of(input logic [26:0] wa, input logic [1:0] pg,
                                         input logic [1:0] bk);
    bank_of = 3'(wa >> (8 + int'(pg))) & 3'((4'h1 << bk) - 4'h1);
  endfunction : bank_of

  function automatic logic [13:0] row_of(input logic [26:0] wa, input logic [1:0] pg,
                                         input logic [1:0] bk);
    row_of = 14'(wa >> (8 + int'(pg) + int'(bk)));
  endfunction : row_of

  wire [26:0] wa = word_addr(req_reg.addr, lcfg_reg.narrow);
  wire [10:0] col = col_of(wa, lcfg_reg.page);
  wire [2:0] sel = lcfg_reg.narrow ? {col[2:1], 1'b0} : col[2:0];
  // R7 latency in link cycles: read 2*cl, write 2*(cl-1)
  wire [4:0] rd_lat = 5'({lcfg_reg.cl, 1'b0} + 3'h4);
  wire [4:0] wr_lat = 5'({lcfg_reg.cl, 1'b0} + 3'h2);
  // R18 sequential burst starts at the aligned column
  wire [13:0] col_a = {2'b00, col[10], 1'b0, col[9:3], 3'h0};
  wire tick = ph_reg;
  wire idle_tick = tick && (wait_reg == 16'h0000);
  wire beat_live = (state_reg == S_DATA) && (dcnt_reg == 5'h00);
  wire beat_hit = lcfg_reg.narrow ? (beat_reg[2:1] == sel[2:1]) : (beat_reg == sel);
  wire [31:0] beat_data = (lcfg_reg.narrow && beat_reg[0]) ? {16'h0, req_reg.wdata[31:16]} :
                          req_reg.wdata;
  wire [3:0] lanes = lcfg_reg.narrow ? 4'h3 : 4'hf;
  wire cap_hit = lcfg_reg.narrow ? (cap_reg[2:1] == sel[2:1]) : (cap_reg == sel);
  // R14 capture only inside the looped-back gate window
  wire cap_en = gate_s[0] && (dqs_s != dqs_prev_reg);
  wire go_req = req_open_reg && (lcfg_reg.self_ref == 1'b0);

  refresh_sched u_refresh (
    .clock(second_pll),
    .rst_n(lrst_n),
    .tick(tick),
    .enable(state_reg != S_SR),
    .interval(lrefi_reg),
    .served(ref_served),
    .need(ref_need),
    .urgent(ref_urgent)
  );

  assign ref_served = idle_tick && (state_reg == S_REF);

  always_comb begin
    cmd_next = '{cmd: ddr_ctrl_pkg::CMD_NOP, ba: 3'h0, a: 14'h0};
    unique case (state_reg)
      S_INIT_PRE, S_PRE: begin
        cmd_next.cmd = ddr_ctrl_pkg::CMD_PRE;
        cmd_next.a[ddr_ctrl_pkg::PRE_ALL_BIT] = 1'b1;
      end
      S_INIT_EMR: begin
        cmd_next.cmd = ddr_ctrl_pkg::CMD_MRS;
        cmd_next.ba = 3'h1;
      end
      S_INIT_MR: begin
        cmd_next.cmd = ddr_ctrl_pkg::CMD_MRS;
        cmd_next.a = ddr_ctrl_pkg::MODE_BURST8 |
                     (14'({1'b0, lcfg_reg.cl} + 3'h2) << ddr_ctrl_pkg::MODE_CL_LSB);
      end
      S_INIT_REF, S_REF, S_SR: cmd_next.cmd = ddr_ctrl_pkg::CMD_REF;
      S_ACT: begin
        cmd_next.cmd = ddr_ctrl_pkg::CMD_ACT;
        cmd_next.ba = bank_of(wa, lcfg_reg.page, lcfg_reg.banks);
        cmd_next.a = row_of(wa, lcfg_reg.page, lcfg_reg.banks);
      end
      S_CMD: begin
        cmd_next.cmd = req_reg.write ? ddr_ctrl_pkg::CMD_WRITE : ddr_ctrl_pkg::CMD_READ;
        cmd_next.ba = bank_of(wa, lcfg_reg.page, lcfg_reg.banks);
        cmd_next.a = col_a;
      end
      default: cmd_next.cmd = ddr_ctrl_pkg::CMD_NOP;
    endcase
  end

  // R2 memory clock is half the link clock
  // R3 the pair comes from two opposite flops
  always_ff @(posedge second_pll) begin
    if (!lrst_n) begin
      ph_reg <= 1'b0;
      mem_clk_p <= 1'b0;
      mem_clk_n <= 1'b1;
    end else begin
      ph_reg <= !ph_reg;
      mem_clk_p <= ph_reg;
      mem_clk_n <= !ph_reg;
    end
  end

  // configuration and request hand-over into this domain
  always_ff @(posedge second_pll) begin
    if (!lrst_n) begin
      lcfg_reg <= ddr_ctrl_pkg::CFG_RESET;
      lrefi_reg <= ddr_ctrl_pkg::REFRESH_RESET;
      cfg_prev_reg <= 1'b0;
      req_prev_reg <= 1'b0;
      req_open_reg <= 1'b0;
    end else begin
      cfg_prev_reg <= cfg_s;
      req_prev_reg <= req_s;
      if (cfg_s != cfg_prev_reg) begin
        lcfg_reg <= cfg_reg;
        lrefi_reg <= refi_reg;
      end
      if (req_s != req_prev_reg) begin
        req_open_reg <= 1'b1;
      end else if (idle_tick && state_reg == S_PRE && req_open_reg) begin
        req_open_reg <= 1'b0;
      end
    end
  end

  // R15 controller sequences banks and refresh itself
  always_ff @(posedge second_pll) begin
    if (!lrst_n) begin
      state_reg <= S_INIT_WAIT;
      wait_reg <= ddr_ctrl_pkg::INIT_WAIT_CYCLES;
      dcnt_reg <= 5'h00;
      beat_reg <= 3'h0;
      ack_tgl_reg <= 1'b0;
      init_done_reg <= 1'b0;
    end else if (state_reg == S_DATA) begin
      if (dcnt_reg != 5'h00) begin
        dcnt_reg <= dcnt_reg - 5'h01;
      end else begin
        beat_reg <= beat_reg + 3'h1;
        if (beat_reg == 3'(ddr_ctrl_pkg::BURST_BEATS - 1)) begin
          state_reg <= S_PRE;
        end
      end
    end else if (tick && wait_reg != 16'h0000) begin
      wait_reg <= wait_reg - 16'h0001;
    end else if (tick) begin
      unique case (state_reg)
        S_INIT_WAIT: state_reg <= S_INIT_PRE;
        S_INIT_PRE: begin
          state_reg <= S_INIT_EMR;
          wait_reg <= ddr_ctrl_pkg::T_RP;
        end
        S_INIT_EMR: begin
          state_reg <= S_INIT_MR;
          wait_reg <= ddr_ctrl_pkg::T_MRD;
        end
        S_INIT_MR: begin
          mr_cl_reg <= lcfg_reg.cl;
          state_reg <= S_INIT_REF;
          wait_reg <= ddr_ctrl_pkg::T_MRD;
        end
        S_INIT_REF: begin
          state_reg <= S_IDLE;
          wait_reg <= ddr_ctrl_pkg::T_RFC;
          init_done_reg <= 1'b1;
        end
        S_IDLE: begin
          // R17 urgent refresh wins, then a cas latency change re-runs init, then accesses, then owed refresh
          if (ref_urgent) begin
            state_reg <= S_REF;
          end else if (mr_cl_reg != lcfg_reg.cl) begin
            state_reg <= S_INIT_PRE;
          end else if (go_req) begin
            state_reg <= S_ACT;
          end else if (ref_need) begin
            state_reg <= S_REF;
          end else if (lcfg_reg.self_ref) begin
            state_reg <= S_SR;
          end
        end
        S_ACT: begin
          state_reg <= S_CMD;
          wait_reg <= ddr_ctrl_pkg::T_RCD;
        end
        S_CMD: begin
          state_reg <= S_DATA;
          dcnt_reg <= req_reg.write ? wr_lat : rd_lat;
          beat_reg <= 3'h0;
        end
        S_PRE: begin
          state_reg <= S_IDLE;
          wait_reg <= ddr_ctrl_pkg::T_RP;
          ack_tgl_reg <= ack_tgl_reg ^ req_open_reg;
        end
        S_REF: begin
          state_reg <= S_IDLE;
          wait_reg <= ddr_ctrl_pkg::T_RFC;
        end
        S_SR: begin
          if (!lcfg_reg.self_ref) begin
            state_reg <= S_SR_EXIT;
          end
        end
        S_SR_EXIT: begin
          state_reg <= S_IDLE;
          wait_reg <= ddr_ctrl_pkg::T_XSR;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // R1 R12 R6 command pins change once per memory clock
  always_ff @(posedge second_pll) begin
    if (!lrst_n) begin
      mem_cs_n <= 1'b0;
      {mem_ras_n, mem_cas_n, mem_we_n} <= ddr_ctrl_pkg::CMD_NOP;
      mem_ba <= 3'h0;
      mem_a <= 14'h0;
      mem_cke <= 1'b0;
      self_ref_reg <= 1'b0;
      termination_ctrl <= 2'h0;
    end else if (tick) begin
      mem_cs_n <= 1'b0;
      {mem_ras_n, mem_cas_n, mem_we_n} <= (idle_tick || state_reg == S_DATA) ?
                                          cmd_next.cmd : ddr_ctrl_pkg::CMD_NOP;
      mem_ba <= cmd_next.ba;
      mem_a <= cmd_next.a;
      // R10 clock enable low holds the memory in self-refresh
      mem_cke <= (state_reg != S_INIT_WAIT) && !(state_reg == S_SR);
      self_ref_reg <= state_reg == S_SR;
      termination_ctrl <= 2'h0;
    end
  end

  // R4 R13 R11 write burst drivers, released outside the burst
  always_ff @(posedge second_pll) begin
    if (!lrst_n) begin
      mem_dq_o <= 32'h0;
      mem_dq_oe_n <= 4'hf;
      mem_dqm_n <= 4'h0;
      mem_dqs_o <= 4'h0;
      mem_dqs_n_o <= 4'hf;
      mem_dqs_oe_n <= 4'hf;
      strobe_gate_loop_o <= 2'h0;
    end else begin
      mem_dq_o <= beat_data;
      mem_dq_oe_n <= (beat_live && req_reg.write) ? ~lanes : 4'hf;
      mem_dqs_oe_n <= (beat_live && req_reg.write) ? ~lanes : 4'hf;
      mem_dqs_o <= {4{beat_live && !beat_reg[0]}};
      mem_dqs_n_o <= {4{!(beat_live && !beat_reg[0])}};
      mem_dqm_n <= (beat_live && beat_hit) ? lanes : 4'h0;
      strobe_gate_loop_o <= {2{beat_live && !req_reg.write}};
    end
  end

  // R14 R5 read beats captured while the returned gate is high
  always_ff @(posedge second_pll) begin
    if (!lrst_n) begin
      dqs_prev_reg <= 1'b0;
      cap_reg <= 3'h0;
      rdata_link_reg <= 32'h0;
    end else begin
      dqs_prev_reg <= dqs_s;
      if (state_reg == S_CMD) begin
        cap_reg <= 3'h0;
      end else if (cap_en) begin
        cap_reg <= cap_reg + 3'h1;
        if (cap_hit && lcfg_reg.narrow) begin
          if (cap_reg[0]) begin
            rdata_link_reg[31:16] <= dq_s[15:0];
          end else begin
            rdata_link_reg[15:0] <= dq_s[15:0];
          end
        end else if (cap_hit) begin
          rdata_link_reg <= dq_s;
        end
      end
    end
  end
endmodule : ddr_ctrl
`default_nettype wire

// file: design/ddr_ctrl_pkg.sv
// constants and carrier types for the dram controller
// How it works
// R1 - memory select stays low from reset onward, never released high
// R2 - memory clock is the second pll output divided by two
// R3 - memory clock pair: second output is the inverse of the first
// R4 - data bus driven only in write bursts, received during reads
// R5 - data bus runs 32 bits wide or 16 bits narrow, chosen by software
// R6 - 14-bit row/column address plus 3-bit bank select outputs
// R7 - cas latency of 2, 3, 4 or 5 memory clocks
// R8 - memories with 1, 2, 4 or 8 internal banks
// R9 - page sizes of 256, 512, 1024 or 2048 columns
// R10 - clock enable puts memory into and out of self-refresh
// R11 - byte mask outputs are active low; low masks the lane
// R12 - row, column and write strobes are active low command encoders
// R13 - data strobes are differential, driven on writes, received on reads
// R14 - strobe gate loop marks when read strobes are captured
// R15 - bank open/close, refresh and arbitration run without the masters
// R16 - masters reach the controller only through the switch fabric port
// R17 - programmable refresh interval with backlog counter and priority
// R18 - every transfer is a sequential burst of eight beats
package ddr_ctrl_pkg;

  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_REFRESH = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  localparam int CFG_NARROW_BIT = 0;
  localparam int CFG_CL_LSB = 2;
  localparam int CFG_BANK_LSB = 4;
  localparam int CFG_PAGE_LSB = 6;
  localparam int CFG_SELF_REF_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SELF_REF_BIT = 1;
  localparam int STAT_INIT_BIT = 2;

  // cas latency 3, four banks, 1024-column pages, 32-bit bus
  localparam logic [8:0] CFG_RESET = 9'h0a4;

  localparam int LINK_CLK_NS = 32;
  localparam int MEM_CLK_NS = 2 * LINK_CLK_NS;
  localparam int REFRESH_PERIOD_NS = 7800;
  localparam logic [15:0] REFRESH_RESET = 16'(REFRESH_PERIOD_NS / MEM_CLK_NS);
  localparam int INIT_WAIT_NS = 200000;
  localparam logic [15:0] INIT_WAIT_CYCLES = 16'((INIT_WAIT_NS + MEM_CLK_NS - 1) / MEM_CLK_NS);

  // memory-clock counts between commands
  localparam logic [15:0] T_RCD = 16'h0003;
  localparam logic [15:0] T_RP = 16'h0004;
  localparam logic [15:0] T_RFC = 16'h0010;
  localparam logic [15:0] T_MRD = 16'h0002;
  localparam logic [15:0] T_XSR = 16'h00c8;

  localparam int BURST_BEATS = 8;
  localparam logic [3:0] BACKLOG_MAX = 4'h8;
  localparam logic [3:0] BACKLOG_URGENT = 4'h4;

  // {row strobe, column strobe, write strobe}, all active low
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;

  // burst length eight, sequential, cas latency in a[6:4]
  localparam logic [13:0] MODE_BURST8 = 14'h0003;
  localparam int MODE_CL_LSB = 4;
  localparam int PRE_ALL_BIT = 10;

  typedef struct packed {
    logic write;
    logic [27:0] addr;
    logic [31:0] wdata;
  } fab_req_t;

  typedef struct packed {
    logic self_ref;
    logic [1:0] page;
    logic [1:0] banks;
    logic [1:0] cl;
    logic spare;
    logic narrow;
  } mem_cfg_t;

  typedef struct packed {
    logic [2:0] cmd;
    logic [2:0] ba;
    logic [13:0] a;
  } mem_cmd_t;

endpackage : ddr_ctrl_pkg

// file: design/sync2.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    meta_reg <= d;
    q <= meta_reg;
  end
endmodule : sync2
`default_nettype wire

// file: design/refresh_sched.sv
// refresh interval counter with postponed-refresh backlog
`timescale 1ns/1ps
`default_nettype none
module refresh_sched (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic enable,
  input wire logic [15:0] interval,
  input wire logic served,
  output logic need,
  output logic urgent
);
  logic [15:0] count_reg;
  logic [3:0] backlog_reg;
  logic [3:0] backlog_next;
  wire expire = enable && tick && (count_reg == 16'h0000);
  wire add = expire && (backlog_reg != ddr_ctrl_pkg::BACKLOG_MAX);
  wire sub = served && (backlog_reg != 4'h0);

  // R17 backlog tracking
  assign backlog_next = backlog_reg + {3'h0, add} - {3'h0, sub};
  assign need = backlog_reg != 4'h0;
  // R17 priority threshold
  assign urgent = backlog_reg >= ddr_ctrl_pkg::BACKLOG_URGENT;

  always_ff @(posedge clock) begin
    if (!rst_n || !enable) begin
      count_reg <= ddr_ctrl_pkg::REFRESH_RESET;
      backlog_reg <= 4'h0;
    end else begin
      backlog_reg <= backlog_next;
      if (expire) begin
        count_reg <= interval;
      end else if (tick) begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end
endmodule : refresh_sched
`default_nettype wire

// file: verif/ddr_ctrl_assertions.sv
// concurrent checks on the controller's memory-side pins
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_assertions (
  input wire logic nrst,
  input wire logic second_pll,
  input wire logic mem_clk_p,
  input wire logic mem_clk_n,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [13:0] mem_a,
  input wire logic [3:0] mem_dq_oe_n,
  input wire logic [1:0] strobe_gate_loop_o
);
  // link reset copy here lags by four flops
  logic [3:0] rst_q;
  wire logic lrst_n = nrst && (&rst_q);
  wire logic [2:0] cmd = {mem_ras_n, mem_cas_n, mem_we_n};
  always_ff @(posedge second_pll) rst_q <= {rst_q[2:0], nrst};
  default clocking cb @(posedge second_pll); endclocking
  default disable iff (!lrst_n);
  sequence s_gate8;
    strobe_gate_loop_o[0] [*8] ##1 !strobe_gate_loop_o[0];
  endsequence
  sequence s_beats8;
    !mem_dq_oe_n[0] [*8] ##1 mem_dq_oe_n[0];
  endsequence
  sequence s_nop4;
    (cmd == ddr_ctrl_pkg::CMD_NOP) [*4];
  endsequence
  property p_cs_low;
    mem_cs_n == 1'b0;
  endproperty
  a_cs_low: assert property (p_cs_low) else $error("select went high");
  property p_clk_pair;
    mem_clk_n == ~mem_clk_p;
  endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("clock pair not inverse");
  property p_clk_half;
    mem_clk_p != $past(mem_clk_p);
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("memory clock not half rate");
  property p_gate8;
    $rose(strobe_gate_loop_o[0]) |-> s_gate8;
  endproperty
  a_gate8: assert property (p_gate8) else $error("gate not eight beats");
  property p_dq_dir;
    mem_dq_oe_n != 4'hf |-> strobe_gate_loop_o == 2'b00;
  endproperty
  a_dq_dir: assert property (p_dq_dir) else $error("data driven during read");
  property p_beats8;
    $fell(mem_dq_oe_n[0]) |-> s_beats8;
  endproperty
  a_beats8: assert property (p_beats8) else $error("write not eight beats");
  property p_act_wait;
    $rose(cmd == ddr_ctrl_pkg::CMD_ACT) |-> ##2 s_nop4;
  endproperty
  a_act_wait: assert property (p_act_wait) else $error("command too soon after open");
  property p_pre_all;
    cmd == ddr_ctrl_pkg::CMD_PRE |-> mem_a[ddr_ctrl_pkg::PRE_ALL_BIT];
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge not all banks");
  property p_sr_entry;
    $fell(mem_cke) |-> cmd == ddr_ctrl_pkg::CMD_REF;
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("clock enable fell without refresh");
endmodule : ddr_ctrl_assertions
bind ddr_ctrl ddr_ctrl_assertions chk (.*);
`default_nettype wire

// file: verif/mem_model.sv
// behavioural single-rank memory on the controller's pins
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic second_pll,
  input wire logic mem_clk_p,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [2:0] mem_ba,
  input wire logic [13:0] mem_a,
  input wire logic [3:0] mem_dqm_n,
  input wire logic [31:0] mem_dq_o,
  input wire logic [3:0] mem_dq_oe_n,
  output logic [31:0] mem_dq_i,
  output logic [3:0] mem_dqs_i
);
  logic [31:0] store [int];
  logic [31:0] w;
  logic [16:0] row_q;
  int key, rk;
  int cl = 3;
  int wb = 8;
  int rw = 0;
  int rb = 0;
  function automatic logic [31:0] word_at(input int k);
    return store.exists(k) ? store[k] : 32'h0;
  endfunction : word_at
  initial begin
    mem_dq_i = 32'h0;
    mem_dqs_i = 4'h0;
  end
  always @(posedge second_pll) begin
    // released lines flip each cycle so stale data never looks valid
    mem_dq_i <= rb > 0 ? word_at(rk + 8 - rb) : ~mem_dq_i;
    mem_dqs_i <= ~mem_dqs_i;
    if (rb > 0) rb--;
    if (rw > 0) begin
      rw--;
      if (rw == 0) rb = 8;
    end
    // only driven, unmasked lanes are stored
    if (mem_dq_oe_n != 4'hf && wb < 8) begin
      w = word_at(key + wb);
      for (int l = 0; l < 4; l++)
        if (mem_dqm_n[l] && !mem_dq_oe_n[l]) w[8*l +: 8] = mem_dq_o[8*l +: 8];
      store[key + wb] = w;
      wb++;
    end
    // commands sampled once per memory clock
    if (mem_clk_p && mem_cke && !mem_cs_n) begin
      case ({mem_ras_n, mem_cas_n, mem_we_n})
        ddr_ctrl_pkg::CMD_MRS: if (mem_ba == 3'h0) cl = int'(mem_a[6:4]);
        ddr_ctrl_pkg::CMD_ACT: row_q = {mem_ba, mem_a};
        ddr_ctrl_pkg::CMD_WRITE: begin
          key = {row_q, mem_a[13:11], mem_a[9:0]};
          wb = 0;
        end
        ddr_ctrl_pkg::CMD_READ: begin
          rk = {row_q, mem_a[13:11], mem_a[9:0]};
          rw = 2 * cl - 1;
        end
        default: ;
      endcase
    end
  end
endmodule : mem_model
`default_nettype wire

// file: verif/ddr2_sdram_controller_interface_test.sv
// self-checking bench: registers, fabric traffic and refresh
`timescale 1ns/1ps
`default_nettype none
module ddr2_sdram_controller_interface_test;
  logic clock = 1'b0;
  logic second_pll = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fab_valid = 1'b0;
  ddr_ctrl_pkg::fab_req_t fab_req = '0;
  logic [31:0] reg_rdata, fab_rdata, mem_dq_i, mem_dq_o, rd;
  logic fab_ready, fab_rvalid, mem_clk_p, mem_clk_n, mem_cke, mem_cs_n;
  logic mem_ras_n, mem_cas_n, mem_we_n;
  logic [2:0] mem_ba;
  logic [13:0] mem_a;
  logic [3:0] mem_dqm_n, mem_dq_oe_n, mem_dqs_i, mem_dqs_o, mem_dqs_n_o, mem_dqs_oe_n;
  logic [1:0] gate_loop, termination_ctrl;
  int bad_count = 0;
  int n_checks = 0;
  int ref_cnt = 0;
  logic [8:0] cfg_v [6] = '{9'h0a4, 9'h0a0, 9'h0f8, 9'h00c, 9'h0a5, 9'h054};
  logic [27:0] adr_v [6] = '{28'h10, 28'h100200, 28'hffffff8, 28'h40, 28'h2008, 28'habcde0};
  logic [31:0] dat_v [6] = '{32'h1234abcd, 32'hffff0000, 32'ha5a55a5a, 32'h1,
                             32'h87654321, 32'hcafef00d};
  ddr_ctrl dut (.*, .strobe_gate_loop_o(gate_loop), .strobe_gate_loop_i(gate_loop));
  mem_model far_mem (.*);
  initial forever #20 clock = ~clock;
  initial begin
    #7;
    forever #16 second_pll = ~second_pll;
  end
  always @(posedge second_pll)
    if (mem_clk_p && {mem_ras_n, mem_cas_n, mem_we_n} == ddr_ctrl_pkg::CMD_REF) ref_cnt++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : reg_read
  // masters reach memory only through the fabric port
  task automatic fab(input logic w, input logic [27:0] ad, input logic [31:0] wd);
    int n = 0;
    @(posedge clock);
    fab_valid <= 1'b1;
    fab_req <= {w, ad, wd};
    do begin
      @(negedge clock);
      n++;
    end while (fab_ready !== 1'b1 && n < 9000);
    @(posedge clock);
    fab_valid <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while ((w ? fab_ready : fab_rvalid) !== 1'b1 && n < 9000);
    if (n >= 9000) bad_count++;
    rd = fab_rdata;
  endtask : fab
  task automatic poll(input logic v);
    int n = 0;
    do begin
      reg_read(ddr_ctrl_pkg::REG_STATUS, rd);
      n++;
    end while (rd[ddr_ctrl_pkg::STAT_SELF_REF_BIT] !== v && n < 500);
    chk(32'(rd[ddr_ctrl_pkg::STAT_SELF_REF_BIT]), 32'(v));
  endtask : poll
  initial begin
    // link side needs the reset too
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    reg_read(ddr_ctrl_pkg::REG_CFG, rd);
    chk(rd, 32'h0a4);
    reg_read(ddr_ctrl_pkg::REG_REFRESH, rd);
    chk(rd, 32'h79);
    reg_write(ddr_ctrl_pkg::REG_STATUS, 32'hffffffff);
    reg_read(ddr_ctrl_pkg::REG_STATUS, rd);
    chk(rd, 32'h0);
    reg_read(8'h0c, rd);
    chk(rd, 32'h0);
    // every width, latency, bank and page code
    for (int i = 0; i < 6; i++) begin
      reg_write(ddr_ctrl_pkg::REG_CFG, 32'(cfg_v[i]));
      reg_read(ddr_ctrl_pkg::REG_CFG, rd);
      chk(rd, 32'(cfg_v[i]));
      fab(1'b1, adr_v[i], dat_v[i]);
      fab(1'b1, adr_v[i] + 28'h4, ~dat_v[i]);
      fab(1'b0, adr_v[i], 32'h0);
      chk(rd, dat_v[i]);
      fab(1'b0, adr_v[i] + 28'h4, 32'h0);
      chk(rd, ~dat_v[i]);
    end
    // short interval gives a known refresh count
    reg_write(ddr_ctrl_pkg::REG_CFG, 32'h0a4);
    reg_write(ddr_ctrl_pkg::REG_REFRESH, 32'h20);
    reg_read(ddr_ctrl_pkg::REG_REFRESH, rd);
    chk(rd, 32'h20);
    repeat (200) @(posedge clock);
    ref_cnt = 0;
    repeat (1000) @(posedge clock);
    chk(32'(ref_cnt inside {[17:21]}), 32'h1);
    // self-refresh entry and exit keep the data
    reg_write(ddr_ctrl_pkg::REG_CFG, 32'h1a4);
    poll(1'b1);
    chk(32'(mem_cke), 32'h0);
    reg_write(ddr_ctrl_pkg::REG_CFG, 32'h0a4);
    poll(1'b0);
    chk(32'(mem_cke), 32'h1);
    fab(1'b0, adr_v[0], 32'h0);
    chk(rd, dat_v[0]);
    finish_test();
  end
  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end
endmodule : ddr2_sdram_controller_interface_test
`default_nettype wire
